// ==== verilog/mfsr_map.vh ====
// register offsets, bit positions and reset values of the fault status bank
`ifndef MFSR_MAP_VH
`define MFSR_MAP_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MFSR_GATE_DRIVER_FAULT_OFS 8'hE0
`define MFSR_CONTROLLER_FAULT_OFS 8'hE2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MFSR_GATE_DRIVER_FAULT_RST 32'h00000000
`define MFSR_CONTROLLER_FAULT_RST 32'h00000000

// ------------------------------------------------------------
// controller fault register bit positions
// ------------------------------------------------------------
`define MFSR_CF_SUMMARY 31
`define MFSR_CF_POS_FREQ 29
`define MFSR_CF_POS_T1 28
`define MFSR_CF_POS_T2 27
`define MFSR_CF_BUS_ILIMIT 26
`define MFSR_CF_MEAS_RL 25
`define MFSR_CF_MEAS_EMF 24
`define MFSR_CF_SPEED_LOCK 23
`define MFSR_CF_EMF_LOCK 22
`define MFSR_CF_NO_MOTOR 21
`define MFSR_CF_LOCK_ANY 20
`define MFSR_CF_LOCK_ILIMIT 19
`define MFSR_CF_HARD_ILIMIT 18
`define MFSR_CF_SUPPLY_LOW 17
`define MFSR_CF_SUPPLY_HIGH 16
`define MFSR_CF_SPEED_SAT 15
`define MFSR_CF_CURRENT_SAT 14
`define MFSR_CF_WATCHDOG 3

// ------------------------------------------------------------
// gate driver fault register bit positions
// ------------------------------------------------------------
`define MFSR_GD_SUMMARY 31
`define MFSR_GD_OC_HC 21
`define MFSR_GD_OC_LC 20
`define MFSR_GD_OC_HB 19
`define MFSR_GD_OC_LB 18
`define MFSR_GD_OC_HA 17
`define MFSR_GD_OC_LA 16
`define MFSR_GD_OTP_ERR 14
`define MFSR_GD_SW_OC 13
`define MFSR_GD_SW_UV 12
`define MFSR_GD_CP_LOW 11

`endif

// ==== verilog/mfsr_fault_status_regs.v ====
// read-only fault status register bank of the motor controller
`timescale 1ns/1ns
`include "mfsr_map.vh"

module mfsr_fault_status_regs #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // host register port
  input wire host_rd_en,
  input wire host_wr_en,
  input wire [ADDR_W-1:0] host_addr,
  input wire [31:0] host_wr_data,
  output reg [31:0] host_rd_data,
  output reg host_ack,
  // controller fault conditions
  input wire pos_detect_freq_error,
  input wire pos_detect_timer1_error,
  input wire pos_detect_timer2_error,
  input wire bus_current_limit_active,
  input wire param_meas_rl_error,
  input wire param_meas_emf_error,
  input wire abnormal_rotor_speed_lock,
  input wire abnormal_emf_lock,
  input wire motor_absent_error,
  input wire lock_current_limit_error,
  input wire hard_lock_current_limit_error,
  input wire supply_low_error,
  input wire supply_high_error,
  input wire speed_loop_saturated,
  input wire current_loop_saturated,
  input wire watchdog_timeout,
  // gate driver fault conditions
  input wire phase_c_high_overcurrent,
  input wire phase_c_low_overcurrent,
  input wire phase_b_high_overcurrent,
  input wire phase_b_low_overcurrent,
  input wire phase_a_high_overcurrent,
  input wire phase_a_low_overcurrent,
  input wire otp_memory_error,
  input wire switcher_overcurrent,
  input wire switcher_undervoltage,
  input wire charge_pump_low,
  // summaries for the fault pin logic
  output wire controller_fault_any,
  output wire gate_driver_fault_any
);

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  // offsets sized to the host address port; the reset words are
  // sliced per flag so each flop starts at its register's reset
  // value
  localparam [ADDR_W-1:0] CTRL_OFS = `MFSR_CONTROLLER_FAULT_OFS;
  localparam [ADDR_W-1:0] GATE_OFS = `MFSR_GATE_DRIVER_FAULT_OFS;
  localparam [31:0] CTRL_RST = `MFSR_CONTROLLER_FAULT_RST;
  localparam [31:0] GATE_RST = `MFSR_GATE_DRIVER_FAULT_RST;

  // ------------------------------------------------------------
  // host request decode
  // ------------------------------------------------------------
  wire host_req;
  wire sel_ctrl;
  wire sel_gate;
  wire unused_wr;

  assign host_req = host_rd_en | host_wr_en;
  assign sel_ctrl = (host_addr == CTRL_OFS);
  assign sel_gate = (host_addr == GATE_OFS);

  // ------------------------------------------------------------
  // controller fault flags
  // ------------------------------------------------------------
  // each flag is its own flop that mirrors its detector one cycle
  // late; the detectors own latching and recovery, so there is no
  // clear path and a read has no side effect
  reg pos_freq_flag;
  reg pos_t1_flag;
  reg pos_t2_flag;
  reg bus_ilimit_flag;
  reg meas_rl_flag;
  reg meas_emf_flag;
  reg speed_lock_flag;
  reg emf_lock_flag;
  reg motor_absent_flag;
  reg lock_any_flag;
  reg lock_ilimit_flag;
  reg hard_ilimit_flag;
  reg supply_low_flag;
  reg supply_high_flag;
  reg speed_sat_flag;
  reg current_sat_flag;
  reg watchdog_flag;
  reg ctrl_summary_flag;
  wire rotor_lock_any;
  wire next_ctrl_summary;

  assign rotor_lock_any = abnormal_rotor_speed_lock | abnormal_emf_lock |
    motor_absent_error | lock_current_limit_error | hard_lock_current_limit_error;

  // controller summary
  // built from the causes rather than the flops, so the summary
  // changes in the same cycle as the flags it covers
  assign next_ctrl_summary = pos_detect_freq_error | pos_detect_timer1_error |
    pos_detect_timer2_error | bus_current_limit_active | param_meas_rl_error |
    param_meas_emf_error | rotor_lock_any | supply_low_error | supply_high_error |
    speed_loop_saturated | current_loop_saturated | watchdog_timeout;

  always @(posedge sys_clk) begin
    if (srst) begin
      pos_freq_flag <= CTRL_RST[`MFSR_CF_POS_FREQ];
      pos_t1_flag <= CTRL_RST[`MFSR_CF_POS_T1];
      pos_t2_flag <= CTRL_RST[`MFSR_CF_POS_T2];
      bus_ilimit_flag <= CTRL_RST[`MFSR_CF_BUS_ILIMIT];
      meas_rl_flag <= CTRL_RST[`MFSR_CF_MEAS_RL];
      meas_emf_flag <= CTRL_RST[`MFSR_CF_MEAS_EMF];
      speed_lock_flag <= CTRL_RST[`MFSR_CF_SPEED_LOCK];
      emf_lock_flag <= CTRL_RST[`MFSR_CF_EMF_LOCK];
      motor_absent_flag <= CTRL_RST[`MFSR_CF_NO_MOTOR];
      lock_any_flag <= CTRL_RST[`MFSR_CF_LOCK_ANY];
      lock_ilimit_flag <= CTRL_RST[`MFSR_CF_LOCK_ILIMIT];
      hard_ilimit_flag <= CTRL_RST[`MFSR_CF_HARD_ILIMIT];
      supply_low_flag <= CTRL_RST[`MFSR_CF_SUPPLY_LOW];
      supply_high_flag <= CTRL_RST[`MFSR_CF_SUPPLY_HIGH];
      speed_sat_flag <= CTRL_RST[`MFSR_CF_SPEED_SAT];
      current_sat_flag <= CTRL_RST[`MFSR_CF_CURRENT_SAT];
      watchdog_flag <= CTRL_RST[`MFSR_CF_WATCHDOG];
      ctrl_summary_flag <= CTRL_RST[`MFSR_CF_SUMMARY];
    end else begin
      pos_freq_flag <= pos_detect_freq_error;
      pos_t1_flag <= pos_detect_timer1_error;
      pos_t2_flag <= pos_detect_timer2_error;
      bus_ilimit_flag <= bus_current_limit_active;
      meas_rl_flag <= param_meas_rl_error;
      meas_emf_flag <= param_meas_emf_error;
      speed_lock_flag <= abnormal_rotor_speed_lock;
      emf_lock_flag <= abnormal_emf_lock;
      motor_absent_flag <= motor_absent_error;
      lock_any_flag <= rotor_lock_any;
      lock_ilimit_flag <= lock_current_limit_error;
      hard_ilimit_flag <= hard_lock_current_limit_error;
      supply_low_flag <= supply_low_error;
      supply_high_flag <= supply_high_error;
      speed_sat_flag <= speed_loop_saturated;
      current_sat_flag <= current_loop_saturated;
      watchdog_flag <= watchdog_timeout;
      ctrl_summary_flag <= next_ctrl_summary;
    end
  end

  // ------------------------------------------------------------
  // gate driver fault flags
  // ------------------------------------------------------------
  // bits 30 to 22 hold faults whose detectors sit outside this
  // bank, so they read zero here
  reg oc_hc_flag;
  reg oc_lc_flag;
  reg oc_hb_flag;
  reg oc_lb_flag;
  reg oc_ha_flag;
  reg oc_la_flag;
  reg otp_err_flag;
  reg sw_oc_flag;
  reg sw_uv_flag;
  reg cp_low_flag;
  reg gate_summary_flag;
  wire next_gate_summary;

  assign next_gate_summary = phase_c_high_overcurrent | phase_c_low_overcurrent |
    phase_b_high_overcurrent | phase_b_low_overcurrent | phase_a_high_overcurrent |
    phase_a_low_overcurrent | otp_memory_error | switcher_overcurrent |
    switcher_undervoltage | charge_pump_low;

  always @(posedge sys_clk) begin
    if (srst) begin
      oc_hc_flag <= GATE_RST[`MFSR_GD_OC_HC];
      oc_lc_flag <= GATE_RST[`MFSR_GD_OC_LC];
      oc_hb_flag <= GATE_RST[`MFSR_GD_OC_HB];
      oc_lb_flag <= GATE_RST[`MFSR_GD_OC_LB];
      oc_ha_flag <= GATE_RST[`MFSR_GD_OC_HA];
      oc_la_flag <= GATE_RST[`MFSR_GD_OC_LA];
      otp_err_flag <= GATE_RST[`MFSR_GD_OTP_ERR];
      sw_oc_flag <= GATE_RST[`MFSR_GD_SW_OC];
      sw_uv_flag <= GATE_RST[`MFSR_GD_SW_UV];
      cp_low_flag <= GATE_RST[`MFSR_GD_CP_LOW];
      gate_summary_flag <= GATE_RST[`MFSR_GD_SUMMARY];
    end else begin
      oc_hc_flag <= phase_c_high_overcurrent;
      oc_lc_flag <= phase_c_low_overcurrent;
      oc_hb_flag <= phase_b_high_overcurrent;
      oc_lb_flag <= phase_b_low_overcurrent;
      oc_ha_flag <= phase_a_high_overcurrent;
      oc_la_flag <= phase_a_low_overcurrent;
      otp_err_flag <= otp_memory_error;
      sw_oc_flag <= switcher_overcurrent;
      sw_uv_flag <= switcher_undervoltage;
      cp_low_flag <= charge_pump_low;
      gate_summary_flag <= next_gate_summary;
    end
  end

  // ------------------------------------------------------------
  // register words
  // ------------------------------------------------------------
  // pure wiring from the flag flops; every bit not named here is
  // reserved and reads zero
  reg [31:0] controller_fault_flags;
  reg [31:0] gate_driver_fault_flags;
  reg [31:0] next_rd_data;

  always @* begin
    controller_fault_flags = 32'h00000000;
    controller_fault_flags[`MFSR_CF_SUMMARY] = ctrl_summary_flag;
    controller_fault_flags[`MFSR_CF_POS_FREQ] = pos_freq_flag;
    controller_fault_flags[`MFSR_CF_POS_T1] = pos_t1_flag;
    controller_fault_flags[`MFSR_CF_POS_T2] = pos_t2_flag;
    controller_fault_flags[`MFSR_CF_BUS_ILIMIT] = bus_ilimit_flag;
    controller_fault_flags[`MFSR_CF_MEAS_RL] = meas_rl_flag;
    controller_fault_flags[`MFSR_CF_MEAS_EMF] = meas_emf_flag;
    controller_fault_flags[`MFSR_CF_SPEED_LOCK] = speed_lock_flag;
    controller_fault_flags[`MFSR_CF_EMF_LOCK] = emf_lock_flag;
    controller_fault_flags[`MFSR_CF_NO_MOTOR] = motor_absent_flag;
    controller_fault_flags[`MFSR_CF_LOCK_ANY] = lock_any_flag;
    controller_fault_flags[`MFSR_CF_LOCK_ILIMIT] = lock_ilimit_flag;
    controller_fault_flags[`MFSR_CF_HARD_ILIMIT] = hard_ilimit_flag;
    controller_fault_flags[`MFSR_CF_SUPPLY_LOW] = supply_low_flag;
    controller_fault_flags[`MFSR_CF_SUPPLY_HIGH] = supply_high_flag;
    controller_fault_flags[`MFSR_CF_SPEED_SAT] = speed_sat_flag;
    controller_fault_flags[`MFSR_CF_CURRENT_SAT] = current_sat_flag;
    controller_fault_flags[`MFSR_CF_WATCHDOG] = watchdog_flag;
  end

  always @* begin
    gate_driver_fault_flags = 32'h00000000;
    gate_driver_fault_flags[`MFSR_GD_SUMMARY] = gate_summary_flag;
    gate_driver_fault_flags[`MFSR_GD_OC_HC] = oc_hc_flag;
    gate_driver_fault_flags[`MFSR_GD_OC_LC] = oc_lc_flag;
    gate_driver_fault_flags[`MFSR_GD_OC_HB] = oc_hb_flag;
    gate_driver_fault_flags[`MFSR_GD_OC_LB] = oc_lb_flag;
    gate_driver_fault_flags[`MFSR_GD_OC_HA] = oc_ha_flag;
    gate_driver_fault_flags[`MFSR_GD_OC_LA] = oc_la_flag;
    gate_driver_fault_flags[`MFSR_GD_OTP_ERR] = otp_err_flag;
    gate_driver_fault_flags[`MFSR_GD_SW_OC] = sw_oc_flag;
    gate_driver_fault_flags[`MFSR_GD_SW_UV] = sw_uv_flag;
    gate_driver_fault_flags[`MFSR_GD_CP_LOW] = cp_low_flag;
  end

  assign controller_fault_any = ctrl_summary_flag;
  assign gate_driver_fault_any = gate_summary_flag;

  // ------------------------------------------------------------
  // host port
  // ------------------------------------------------------------
  // reads and writes answer one cycle later; back-to-back
  // requests on every cycle are fine
  // unmapped reads zero
  always @* begin
    next_rd_data = 32'h00000000;
    if (sel_ctrl) begin
      next_rd_data = controller_fault_flags;
    end else if (sel_gate) begin
      next_rd_data = gate_driver_fault_flags;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      host_rd_data <= 32'h00000000;
      host_ack <= 1'b0;
    end else begin
      host_ack <= host_req;
      // read data holds until the next read, so a write between
      // reads leaves the last answer visible
      if (host_rd_en) begin
        host_rd_data <= next_rd_data;
      end
    end
  end

  // writes acknowledged only
  // write data has no destination in a read-only bank
  assign unused_wr = host_wr_en & (^host_wr_data);

endmodule // mfsr_fault_status_regs

// ==== testbench/mfsr_checker.sv ====
// concurrent checks on the fault status bank ports
`timescale 1ns/1ns
module mfsr_checker (
  // clock, reset and host port
  input wire sys_clk, srst, host_rd_en, host_wr_en, host_ack,
  input wire [7:0] host_addr,
  input wire [31:0] host_rd_data,
  // summaries and two of their causes
  input wire controller_fault_any, gate_driver_fault_any,
  input wire supply_low_error, phase_a_low_overcurrent
);
  wire req = host_rd_en | host_wr_en;
  wire rd_other = host_rd_en && host_addr != 8'hE0 && host_addr != 8'hE2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_rd_ctrl; host_rd_en && host_addr == 8'hE2; endsequence
  sequence s_rd_gate; host_rd_en && host_addr == 8'hE0; endsequence
  a_ack_follows: assert property (req && !srst |=> host_ack)
    else $error("no ack");
  a_no_stray_ack: assert property (!req |=> !host_ack)
    else $error("stray ack");
  a_rdata_holds: assert property (!host_rd_en |=> $stable(host_rd_data))
    else $error("read data moved");
  a_ctrl_reserved: assert property (s_rd_ctrl |=> (host_rd_data & 32'h40003FF7) == 0)
    else $error("ctrl reserved set");
  a_gate_reserved: assert property (s_rd_gate |=> (host_rd_data & 32'h7FC087FF) == 0)
    else $error("gate reserved set");
  a_unmapped_zero: assert property (rd_other |=> host_rd_data == 0)
    else $error("unmapped not zero");
  a_ctrl_summary: assert property (supply_low_error && !srst |=> controller_fault_any)
    else $error("ctrl summary low");
  a_gate_summary: assert property (phase_a_low_overcurrent && !srst |=> gate_driver_fault_any)
    else $error("gate summary low");
endmodule // mfsr_checker
bind mfsr_fault_status_regs mfsr_checker mfsr_checker_i (.*);

// ==== testbench/tb.sv ====
// self-checking bench for the fault status bank
`timescale 1ns/1ns
module tb;
  reg sys_clk = 0, srst = 1, rd = 0, wr = 0;
  reg [7:0] adr = 8'h00;
  reg [31:0] sd = 32'h0, seed = 32'h3005, got;
  reg [25:0] f = 26'h0;
  wire [31:0] rdat;
  wire ack, cany, gany;
  integer error_cnt = 0, cmp_count = 0, i, n;
  always #5 sys_clk = ~sys_clk;
  mfsr_fault_status_regs mfsr_fault_status_regs_i (.sys_clk(sys_clk), .srst(srst),
    .host_rd_en(rd), .host_wr_en(wr), .host_addr(adr), .host_wr_data(sd), .host_rd_data(rdat),
    .host_ack(ack), .controller_fault_any(cany), .gate_driver_fault_any(gany),
    .pos_detect_freq_error(f[15]), .pos_detect_timer1_error(f[14]),
    .pos_detect_timer2_error(f[13]), .bus_current_limit_active(f[12]),
    .param_meas_rl_error(f[11]), .param_meas_emf_error(f[10]),
    .abnormal_rotor_speed_lock(f[9]), .abnormal_emf_lock(f[8]), .motor_absent_error(f[7]),
    .lock_current_limit_error(f[6]), .hard_lock_current_limit_error(f[5]),
    .supply_low_error(f[4]), .supply_high_error(f[3]), .speed_loop_saturated(f[2]),
    .current_loop_saturated(f[1]), .watchdog_timeout(f[0]),
    .phase_c_high_overcurrent(f[25]), .phase_c_low_overcurrent(f[24]),
    .phase_b_high_overcurrent(f[23]), .phase_b_low_overcurrent(f[22]),
    .phase_a_high_overcurrent(f[21]), .phase_a_low_overcurrent(f[20]),
    .otp_memory_error(f[19]), .switcher_overcurrent(f[18]),
    .switcher_undervoltage(f[17]), .charge_pump_low(f[16]));
  // lock-any bit 20 is the OR of the five lock causes
  function [31:0] ec(input [25:0] v);
    begin
      ec = {2'h0, v[15:7], |v[9:5], v[6:1], 10'h000, v[0], 3'h0};
      ec[31] = |ec;
    end
  endfunction
  function [31:0] eg(input [25:0] v);
    begin
      eg = {10'h000, v[25:20], 1'h0, v[19:16], 11'h000};
      eg[31] = |eg;
    end
  endfunction
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // one host access; write data is random and must be ignored
  task acc(input r, input [7:0] a);
    begin
      @(posedge sys_clk);
      rd <= r;
      wr <= ~r;
      adr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      wr <= 1'b0;
      n = 0;
      @(negedge sys_clk);
      while (ack !== 1'b1 && n < 3) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      if (ack !== 1'b1) begin
        error_cnt = error_cnt + 1;
        final_report;
      end
      got = rdat;
    end
  endtask
  // flags are live levels, so let them settle before reading
  task tv(input [25:0] v);
    begin
      @(posedge sys_clk);
      f <= v;
      repeat (3) @(posedge sys_clk);
      acc(1'b1, 8'hE2);
      chk(got, ec(v));
      chk(cany, ec(v) >> 31);
      acc(1'b1, 8'hE0);
      chk(got, eg(v));
      chk(gany, eg(v) >> 31);
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    tv(26'h0);
    $display("test reset_zero done");
    for (i = 0; i < 26; i = i + 1)
      tv(26'h1 << i);
    tv(26'h3FFFFFF);
    $display("test one_hot done");
    for (i = 0; i < 20; i = i + 1) begin
      seed = xs(seed);
      tv(seed[25:0]);
    end
    $display("test random done");
    seed = xs(seed);
    @(posedge sys_clk);
    sd <= seed;
    acc(1'b0, 8'hE2);
    acc(1'b0, 8'hE0);
    tv(f);
    acc(1'b1, 8'hE4);
    chk(got, 32'h0);
    $display("test write_unmapped done");
    // mid-run reset with every cause raised must clear all outputs
    @(posedge sys_clk);
    f <= 26'h3FFFFFF;
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({ack, cany, gany}, 32'h0);
    chk(rdat, 32'h0);
    @(posedge sys_clk);
    srst <= 1'b0;
    tv(f);
    $display("test mid_reset done");
    final_report;
  end
endmodule // tb
